// file: rtl/cpu_status_datapath.v
// How it works
// [RULE1] direct address is 9-bit page pointer above 7 instruction bits
// [RULE2] page pointer changes only on load-status or load-page writes
// [RULE3] mask 0 passes unmasked interrupts; mask 1 blocks all maskable ones
// [RULE4] mask never blocks reset or nmi; load-status leaves mask alone
// [RULE5] mask set by reset and when a maskable interrupt trap is taken
// [RULE6] overflow flag latches; cleared by reset, ov branch or load-status
// [RULE7] saturate mode 0 wraps, 1 saturates to most positive or negative
// [RULE8] product shift 00 none, 01 left one, 10 left four, zero fill
// [RULE9] product shift 11 is arithmetic right shift by six
// [RULE10] shift only on product path; product register itself unchanged
// [RULE11] product mode written by set-mode and load-status-one; reset clears
// [RULE12] sign extend mode 1 extends scaler data, 0 suppresses; reset sets
// [RULE13] add-no-extend style instructions always suppress sign extension
// [RULE14] test flag set by bit test, aux compare or normalize msb differ
// [RULE15] external flag drives output pin; set/clear bit; reset sets it
// [RULE16] scaler takes 16-bit bus data to 32 bits with no latency
// [RULE17] scaler shifts left 0 to 16; low zeros, high zero or sign
// [RULE18] shift count comes from instruction field or operand register
// [RULE19] multiplier gives signed or unsigned 32-bit product in one cycle
// [RULE20] all multiplies but unsigned treat operands as two's complement
// [RULE21] 16-bit operand register and 32-bit product register held
// [RULE22] arithmetic unit and accumulator are 32 bits wide
// [RULE23] reserved status bits read back as one
// [RULE24] status fields hold between instructions unless written or updated
`timescale 1ns/1ps
`default_nettype none
`include "cpu_status_defines.vh"

module cpu_status_datapath
  (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    // status load and store
    input  wire        load_status_a_i,
    input  wire        load_status_b_i,
    input  wire [15:0] status_data_i,
    output reg  [15:0] status_word_a_o,
    output reg  [15:0] status_word_b_o,
    // page pointer and direct address
    input  wire        load_page_instr_i,
    input  wire [8:0]  page_value_i,
    input  wire [6:0]  instr_low_i,
    output reg  [15:0] direct_addr_o,
    // bit set and clear
    input  wire        set_bit_instr_i,
    input  wire        clear_bit_instr_i,
    input  wire [2:0]  bit_sel_i,
    input  wire        set_product_mode_instr_i,
    input  wire [1:0]  product_mode_value_i,
    // interrupts
    input  wire        irq_pending_i,
    input  wire        irq_trap_taken_i,
    output reg         irq_accept_o,
    // overflow and test events
    input  wire        conditional_branch_ov_i,
    input  wire        bit_test_one_i,
    input  wire        aux_compare_true_i,
    input  wire        normalize_instr_i,
    // scaler
    input  wire [15:0] bus_data_i,
    input  wire        shift_from_operand_i,
    input  wire [4:0]  shift_const_i,
    input  wire        add_no_extend_instr_i,
    // multiplier
    input  wire        load_operand_i,
    input  wire        multiply_i,
    input  wire        unsigned_multiply_instr_i,
    // arithmetic unit
    input  wire        acc_load_i,
    input  wire        acc_add_i,
    input  wire        operand_from_product_i,
    // outputs
    output reg  [31:0] accumulator_reg_o,
    output reg  [31:0] product_reg_o,
    output reg  [15:0] mult_operand_reg_o,
    output reg         overflow_flag_o,
    output reg         external_flag_out_o
  );

  // reset release synchroniser
  reg        rst_meta;
  reg        rst_sync_n;

  // status fields
  reg  [8:0] page_pointer;
  reg        global_irq_mask;
  reg        overflow_saturate_mode;
  reg  [1:0] product_shift_mode;
  reg        sign_extend_mode;
  reg        test_flag;
  reg  [2:0] aux_reg_select;
  reg  [2:0] arb_field;
  reg        carry_bit;
  reg        cnf_bit;

  // datapath
  reg  [31:0] next_acc;
  reg  [31:0] product_shifter;
  reg  [31:0] alu_operand;
  reg  [32:0] sum_ext;
  reg         overflow_event;
  wire [31:0] scaled;
  wire [4:0]  shift_amount;
  wire        sign_ext_eff;
  wire [31:0] mult_result;
  wire signed [32:0] mult_signed;
  wire [15:0] next_status_a;
  wire [15:0] next_status_b;
  wire        set_op;
  wire        clr_op;

  // reset is released synchronously; assertion stays asynchronous
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  assign set_op = set_bit_instr_i & ~clear_bit_instr_i;
  assign clr_op = clear_bit_instr_i & ~set_bit_instr_i;

  // shift count source, low five bits of operand register
  assign shift_amount = shift_from_operand_i ? mult_operand_reg_o[4:0]
                                             : shift_const_i; // RULE18
  assign sign_ext_eff = sign_extend_mode & ~add_no_extend_instr_i; // RULE12 RULE13

  input_scaler u_input_scaler
  (
    .data_i     (bus_data_i),
    .shift_i    (shift_amount),
    .sign_ext_i (sign_ext_eff),
    .data_o     (scaled)
  );

  // one-cycle multiplier; unsigned mode zero-extends both operands
  assign mult_signed = $signed({unsigned_multiply_instr_i ? 1'b0
                                : mult_operand_reg_o[15],
                                mult_operand_reg_o})
                     * $signed({unsigned_multiply_instr_i ? 1'b0
                                : bus_data_i[15], bus_data_i}); // RULE19 RULE20
  assign mult_result = mult_signed[31:0]; // RULE19

  // product scaling only on the read path toward the arithmetic unit
  always @*
  begin
    case (product_shift_mode)
      `PM_NONE:   product_shifter = product_reg_o; // RULE8 RULE10
      `PM_LEFT1:  product_shifter = {product_reg_o[30:0], 1'b0}; // RULE8
      `PM_LEFT4:  product_shifter = {product_reg_o[27:0], 4'h0}; // RULE8
      `PM_RIGHT6: product_shifter = {{6{product_reg_o[31]}},
                                     product_reg_o[31:6]}; // RULE9
      default:    product_shifter = product_reg_o;
    endcase
  end

  // 32-bit add with signed overflow detect and optional saturation
  always @*
  begin
    alu_operand    = operand_from_product_i ? product_shifter : scaled;
    sum_ext        = {accumulator_reg_o[31], accumulator_reg_o}
                   + {alu_operand[31], alu_operand}; // RULE22
    overflow_event = 1'b0;
    next_acc       = accumulator_reg_o;
    if (acc_load_i)
      next_acc = alu_operand;
    else if (acc_add_i)
    begin
      overflow_event = sum_ext[32] ^ sum_ext[31];
      if (overflow_event && overflow_saturate_mode)
        next_acc = sum_ext[32] ? `ACC_MAX_NEG : `ACC_MAX_POS; // RULE7
      else
        next_acc = sum_ext[31:0]; // RULE7
    end
  end

  // status images with reserved bits forced high
  assign next_status_a = {aux_reg_select, overflow_flag_o,
                          overflow_saturate_mode, 1'b1,
                          global_irq_mask, page_pointer}; // RULE23
  assign next_status_b = {arb_field, cnf_bit, test_flag, sign_extend_mode,
                          carry_bit, 4'hf, external_flag_out_o,
                          2'h3, product_shift_mode}; // RULE23

  // status fields; held unless a write or event touches them
  always @(posedge ref_clk_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      page_pointer           <= `RST_PAGE;
      global_irq_mask        <= `RST_IRQ_MASK; // RULE5
      overflow_saturate_mode <= `RST_OVM;
      overflow_flag_o        <= `RST_OVF; // RULE6
      product_shift_mode     <= `RST_PM; // RULE11
      sign_extend_mode       <= `RST_SXM; // RULE12
      test_flag              <= `RST_TC;
      external_flag_out_o    <= `RST_XF; // RULE15
      aux_reg_select         <= 3'h0;
      arb_field              <= 3'h0;
      carry_bit              <= 1'b1;
      cnf_bit                <= 1'b0;
    end
    else
    begin
      // page pointer only via load-status or load-page
      if (load_status_a_i)
        page_pointer <= status_data_i[`SWA_PAGE_MSB:`SWA_PAGE_LSB]; // RULE2
      else if (load_page_instr_i)
        page_pointer <= page_value_i; // RULE2
      // load-status a deliberately leaves the mask alone
      if (irq_trap_taken_i)
        global_irq_mask <= 1'b1; // RULE5
      else if ((set_op | clr_op) && bit_sel_i == `BIT_SEL_IRQ_MASK)
        global_irq_mask <= set_op; // RULE4
      if (load_status_a_i)
      begin
        overflow_saturate_mode <= status_data_i[`SWA_OVM_BIT];
        aux_reg_select <= status_data_i[`SWA_ARP_MSB:`SWA_ARP_LSB];
      end
      else if ((set_op | clr_op) && bit_sel_i == `BIT_SEL_OVM)
        overflow_saturate_mode <= set_op;
      // overflow event wins over any clear in the same cycle
      if (overflow_event)
        overflow_flag_o <= 1'b1; // RULE6
      else if (load_status_a_i)
        overflow_flag_o <= status_data_i[`SWA_OVF_BIT]; // RULE6
      else if (conditional_branch_ov_i)
        overflow_flag_o <= 1'b0; // RULE6
      if (load_status_b_i)
        product_shift_mode <= status_data_i[`SWB_PM_MSB:`SWB_PM_LSB]; // RULE11
      else if (set_product_mode_instr_i)
        product_shift_mode <= product_mode_value_i; // RULE11
      if (load_status_b_i)
        sign_extend_mode <= status_data_i[`SWB_SXM_BIT];
      else if ((set_op | clr_op) && bit_sel_i == `BIT_SEL_SXM)
        sign_extend_mode <= set_op; // RULE12
      // hardware set beats software clear or load
      if (bit_test_one_i || aux_compare_true_i ||
          (normalize_instr_i &&
           (accumulator_reg_o[31] ^ accumulator_reg_o[30])))
        test_flag <= 1'b1; // RULE14
      else if (normalize_instr_i)
        test_flag <= 1'b0;
      else if (load_status_b_i)
        test_flag <= status_data_i[`SWB_TC_BIT];
      else if ((set_op | clr_op) && bit_sel_i == `BIT_SEL_TC)
        test_flag <= set_op;
      if (load_status_b_i)
        external_flag_out_o <= status_data_i[`SWB_XF_BIT];
      else if ((set_op | clr_op) && bit_sel_i == `BIT_SEL_XF)
        external_flag_out_o <= set_op; // RULE15
      if (load_status_b_i)
      begin
        arb_field <= status_data_i[`SWB_ARB_MSB:`SWB_ARB_LSB];
        cnf_bit   <= status_data_i[`SWB_CNF_BIT];
        carry_bit <= status_data_i[`SWB_C_BIT];
      end
    end
  end

  // datapath registers and registered views
  always @(posedge ref_clk_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      accumulator_reg_o  <= 32'h00000000;
      product_reg_o      <= 32'h00000000;
      mult_operand_reg_o <= 16'h0000;
      status_word_a_o    <= 16'h0000;
      status_word_b_o    <= 16'h0000;
      direct_addr_o      <= 16'h0000;
      irq_accept_o       <= 1'b0;
    end
    else
    begin
      accumulator_reg_o <= next_acc; // RULE22
      if (load_operand_i)
        mult_operand_reg_o <= bus_data_i; // RULE21
      if (multiply_i)
        product_reg_o <= mult_result; // RULE21 RULE10
      status_word_a_o <= next_status_a; // RULE24
      status_word_b_o <= next_status_b; // RULE24
      direct_addr_o   <= {page_pointer, instr_low_i}; // RULE1
      // nmi and reset never pass through this gate
      irq_accept_o    <= irq_pending_i & ~global_irq_mask; // RULE3 RULE4
    end
  end

endmodule

`default_nettype wire

// file: inc/cpu_status_defines.vh
`ifndef CPU_STATUS_DEFINES_VH
`define CPU_STATUS_DEFINES_VH

// status word a field positions
`define SWA_PAGE_LSB      0
`define SWA_PAGE_MSB      8
`define SWA_IRQ_MASK_BIT  9
`define SWA_RSVD_BIT      10
`define SWA_OVM_BIT       11
`define SWA_OVF_BIT       12
`define SWA_ARP_LSB       13
`define SWA_ARP_MSB       15

// status word b field positions
`define SWB_PM_LSB        0
`define SWB_PM_MSB        1
`define SWB_XF_BIT        4
`define SWB_C_BIT         9
`define SWB_SXM_BIT       10
`define SWB_TC_BIT        11
`define SWB_CNF_BIT       12
`define SWB_ARB_LSB       13
`define SWB_ARB_MSB       15
`define SWB_RSVD_MASK     16'h01ec

// reset values
`define RST_PAGE          9'h000
`define RST_IRQ_MASK      1'b1
`define RST_OVF           1'b0
`define RST_OVM           1'b0
`define RST_PM            2'h0
`define RST_SXM           1'b1
`define RST_TC            1'b0
`define RST_XF            1'b1

// product shift mode codes and amounts
`define PM_NONE           2'h0
`define PM_LEFT1          2'h1
`define PM_LEFT4          2'h2
`define PM_RIGHT6         2'h3

// selectors for set/clear bit instruction
`define BIT_SEL_IRQ_MASK  3'h0
`define BIT_SEL_OVM       3'h1
`define BIT_SEL_SXM       3'h2
`define BIT_SEL_TC        3'h3
`define BIT_SEL_XF        3'h4

// saturation limits
`define ACC_MAX_POS       32'h7fffffff
`define ACC_MAX_NEG       32'h80000000

`endif

// file: rtl/input_scaler.v
`timescale 1ns/1ps
`default_nettype none

// combinational left shift 0..16 from 16-bit bus into 32-bit arith input
module input_scaler
  (
    // operand
    input  wire [15:0] data_i,
    input  wire [4:0]  shift_i,
    input  wire        sign_ext_i,
    // result
    output wire [31:0] data_o
  );

  wire [31:0] extended;
  wire [4:0]  amount;

  // high half gets sign copies or zeros
  assign extended = {{16{sign_ext_i & data_i[15]}}, data_i}; // RULE17
  // counts above sixteen clamp, the shifter only spans 0..16
  assign amount   = (shift_i > 5'h10) ? 5'h10 : shift_i; // RULE17
  assign data_o   = extended << amount; // RULE16

endmodule

`default_nettype wire

// file: testbench/status_checker.sv
`timescale 1ns/1ps
`default_nettype none
// watches the datapath ports; status images lag their fields by one edge
module status_checker
  (
    // clock and reset
    input wire        ref_clk_i,
    input wire        arst_n_i,
    // strobes
    input wire        load_status_a_i,
    input wire        load_page_instr_i,
    input wire        set_bit_instr_i,
    input wire        clear_bit_instr_i,
    input wire        irq_pending_i,
    input wire        irq_trap_taken_i,
    input wire        irq_accept_o,
    input wire        multiply_i,
    input wire        unsigned_multiply_instr_i,
    input wire        acc_load_i,
    input wire        operand_from_product_i,
    input wire        shift_from_operand_i,
    input wire        add_no_extend_instr_i,
    // data
    input wire [8:0]  page_value_i,
    input wire [6:0]  instr_low_i,
    input wire [4:0]  shift_const_i,
    input wire [15:0] status_word_a_o,
    input wire [15:0] status_word_b_o,
    input wire [15:0] direct_addr_o,
    input wire [15:0] bus_data_i,
    input wire [15:0] mult_operand_reg_o,
    input wire [31:0] product_reg_o,
    input wire [31:0] accumulator_reg_o
  );
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // age keeps image checks out of the reset sync window
  logic [2:0] age;
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  wire live = age > 3'h4;
  // products formed here so that $past sees plain signals
  wire signed [31:0] sp = $signed(mult_operand_reg_o) * $signed(bus_data_i);
  wire [31:0] upr = mult_operand_reg_o * bus_data_i;
  function automatic [31:0] scl(input [15:0] d, input [15:0] o,
                                input [4:0] c, input f, input e);
    logic [4:0] s;
    s = f ? o[4:0] : c;
    scl = {{16{e & d[15]}}, d} << (s > 5'h10 ? 5'h10 : s);
  endfunction
  function automatic [31:0] psh(input [31:0] p, input [1:0] m);
    case (m)
      2'h0: psh = p;
      2'h1: psh = p << 1;
      2'h2: psh = p << 4;
      default: psh = {{6{p[31]}}, p[31:6]};
    endcase
  endfunction
  page_load_a: assert property (load_page_instr_i && !load_status_a_i
    |-> ##2 status_word_a_o[8:0] == $past(page_value_i, 2))
    else $error("page pointer load lost");
  dir_addr_a: assert property (live
    |-> direct_addr_o == {status_word_a_o[8:0], $past(instr_low_i)})
    else $error("direct address wrong");
  rsvd_ones_a: assert property (live |-> status_word_a_o[10]
    && status_word_b_o[8:5] == 4'hf && status_word_b_o[3:2] == 2'h3)
    else $error("reserved status bit low");
  mask_keep_a: assert property (load_status_a_i && !set_bit_instr_i
    && !clear_bit_instr_i && !irq_trap_taken_i
    |-> ##2 $stable(status_word_a_o[9])) else $error("status load hit mask");
  trap_mask_a: assert property (irq_trap_taken_i
    |-> ##2 status_word_a_o[9]) else $error("trap left mask clear");
  irq_gate_a: assert property (live && $stable(status_word_a_o[9])
    |-> irq_accept_o == ($past(irq_pending_i) & !status_word_a_o[9]))
    else $error("interrupt gating wrong");
  mult_res_a: assert property (multiply_i |=> product_reg_o ==
    ($past(unsigned_multiply_instr_i) ? $past(upr) : $past(sp)))
    else $error("product wrong");
  prod_hold_a: assert property (!multiply_i
    |=> $stable(product_reg_o)) else $error("product register moved");
  scale_acc_a: assert property (acc_load_i && !operand_from_product_i
    |=> accumulator_reg_o == scl($past(bus_data_i), $past(mult_operand_reg_o),
    $past(shift_const_i), $past(shift_from_operand_i),
    status_word_b_o[10] & !$past(add_no_extend_instr_i)))
    else $error("scaled load wrong");
  pshift_acc_a: assert property (acc_load_i && operand_from_product_i
    |=> accumulator_reg_o == psh($past(product_reg_o), status_word_b_o[1:0]))
    else $error("product shift wrong");
endmodule
bind cpu_status_datapath status_checker chk (.*);
`default_nettype wire

// file: testbench/irq_source.sv
`timescale 1ns/1ps
`default_nettype none
// interrupt side of the decoder: holds a request until its trap is taken
module irq_source (
  // clock and reset
  input  wire  ref_clk_i,
  input  wire  arst_n_i,
  // request and grant
  input  wire  raise_i,
  input  wire  accept_i,
  // toward the datapath
  output logic pend_o,
  output logic trap_o
);
  // one trap per grant; request drops as the trap fires, so no double trap
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      pend_o <= 1'b0;
      trap_o <= 1'b0;
    end
    else
    begin
      trap_o <= accept_i & pend_o & !trap_o;
      if (trap_o)
        pend_o <= 1'b0;
      else if (raise_i)
        pend_o <= 1'b1;
    end
endmodule
`default_nettype wire

// file: testbench/dsp_cpu_status_shift_multiply_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dsp_cpu_status_shift_multiply_tb;
  logic        ref_clk_i, arst_n_i, raise, load_status_a_i, load_status_b_i;
  logic        load_page_instr_i, set_bit_instr_i, clear_bit_instr_i;
  logic        set_product_mode_instr_i, conditional_branch_ov_i;
  logic        bit_test_one_i, aux_compare_true_i, normalize_instr_i;
  logic        shift_from_operand_i, add_no_extend_instr_i, load_operand_i;
  logic        multiply_i, unsigned_multiply_instr_i, acc_load_i, acc_add_i;
  logic        operand_from_product_i;
  logic [15:0] status_data_i, bus_data_i;
  logic [8:0]  page_value_i;
  logic [6:0]  instr_low_i;
  logic [4:0]  shift_const_i;
  logic [2:0]  bit_sel_i;
  logic [1:0]  product_mode_value_i;
  wire         irq_pending_i, irq_trap_taken_i, irq_accept_o;
  wire         overflow_flag_o, external_flag_out_o;
  wire [15:0]  status_word_a_o, status_word_b_o, direct_addr_o;
  wire [15:0]  mult_operand_reg_o;
  wire [31:0]  accumulator_reg_o, product_reg_o;
  int          errors, cmp_count;
  logic [31:0] pexp [4] = '{32'hffffc964, 32'hffff92c8, 32'hfffc9640,
                            32'hffffff25};
  cpu_status_datapath dut (.*);
  irq_source far (.ref_clk_i, .arst_n_i, .raise_i(raise),
    .accept_i(irq_accept_o), .pend_o(irq_pending_i),
    .trap_o(irq_trap_taken_i));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic give_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one-cycle set or clear of a selected status bit
  task automatic bitop(input logic set, input logic [2:0] sel);
    @(posedge ref_clk_i);
    set_bit_instr_i <= set;
    clear_bit_instr_i <= !set;
    bit_sel_i <= sel;
    @(posedge ref_clk_i);
    set_bit_instr_i <= 1'b0;
    clear_bit_instr_i <= 1'b0;
  endtask
  // page load then a status load, which must not touch the mask
  task automatic t_page;
    @(posedge ref_clk_i);
    load_page_instr_i <= 1'b1;
    page_value_i <= 9'h1a5;
    instr_low_i <= 7'h33;
    @(posedge ref_clk_i);
    load_page_instr_i <= 1'b0;
    tick(2);
    `CHK(direct_addr_o, {9'h1a5, 7'h33})
    @(posedge ref_clk_i);
    load_status_a_i <= 1'b1;
    @(posedge ref_clk_i);
    load_status_a_i <= 1'b0;
    tick(2);
    `CHK(status_word_a_o[9:0], 10'h200)
    `CHK(direct_addr_o[15:7], 9'h000)
  endtask
  // request held off by the mask, then granted and trapped
  task automatic t_irq;
    @(posedge ref_clk_i);
    raise <= 1'b1;
    @(posedge ref_clk_i);
    raise <= 1'b0;
    tick(4);
    `CHK(irq_accept_o, 1'b0)
    bitop(1'b0, 3'h0);
    for (int i = 0; i < 10 && irq_trap_taken_i !== 1'b1; i++)
      tick(1);
    `CHK(irq_trap_taken_i, 1'b1)
    tick(3);
    `CHK(status_word_a_o[9], 1'b1)
    `CHK(irq_accept_o, 1'b0)
  endtask
  // back-to-back unsigned and signed multiply, then all four shift codes
  task automatic t_mult;
    @(posedge ref_clk_i);
    load_operand_i <= 1'b1;
    bus_data_i <= 16'hfffd;
    @(posedge ref_clk_i);
    load_operand_i <= 1'b0;
    multiply_i <= 1'b1;
    unsigned_multiply_instr_i <= 1'b1;
    bus_data_i <= 16'h1234;
    @(posedge ref_clk_i);
    unsigned_multiply_instr_i <= 1'b0;
    #1 `CHK(product_reg_o, 32'h1233c964)
    @(posedge ref_clk_i);
    multiply_i <= 1'b0;
    #1 `CHK(product_reg_o, 32'hffffc964)
    for (int m = 0; m < 4; m++)
    begin
      @(posedge ref_clk_i);
      set_product_mode_instr_i <= 1'b1;
      product_mode_value_i <= 2'(m);
      @(posedge ref_clk_i);
      set_product_mode_instr_i <= 1'b0;
      acc_load_i <= 1'b1;
      operand_from_product_i <= 1'b1;
      @(posedge ref_clk_i);
      acc_load_i <= 1'b0;
      operand_from_product_i <= 1'b0;
      #1 `CHK(accumulator_reg_o, pexp[m])
      `CHK(product_reg_o, 32'hffffc964)
    end
    tick(1);
    `CHK(status_word_b_o[1:0], 2'h3)
  endtask
  // one scaled load into the accumulator
  task automatic scale(input logic [15:0] d, input logic [4:0] sh,
                       input logic fo, input logic nx, input logic [31:0] e);
    @(posedge ref_clk_i);
    bus_data_i <= d;
    shift_const_i <= sh;
    shift_from_operand_i <= fo;
    add_no_extend_instr_i <= nx;
    acc_load_i <= 1'b1;
    @(posedge ref_clk_i);
    acc_load_i <= 1'b0;
    shift_from_operand_i <= 1'b0;
    add_no_extend_instr_i <= 1'b0;
    #1 `CHK(accumulator_reg_o, e)
  endtask
  // one test flag event: 0 aux compare, 1 normalize, 2 bit test
  task automatic t_tc(input int k, input logic e);
    @(posedge ref_clk_i);
    aux_compare_true_i <= (k == 0);
    normalize_instr_i <= (k == 1);
    bit_test_one_i <= (k == 2);
    @(posedge ref_clk_i);
    {aux_compare_true_i, normalize_instr_i, bit_test_one_i} <= 3'h0;
    tick(1);
    `CHK(status_word_b_o[11], e)
  endtask
  // scaled load then an overflowing add; wrap or saturate by mode
  task automatic t_ovf(input logic sat, input logic [31:0] e);
    if (sat)
      bitop(1'b1, 3'h1);
    scale(16'h7fff, 5'h10, 1'b0, 1'b0, 32'h7fff0000);
    `CHK(overflow_flag_o, sat)
    @(posedge ref_clk_i);
    acc_add_i <= 1'b1;
    @(posedge ref_clk_i);
    acc_add_i <= 1'b0;
    #1 `CHK(accumulator_reg_o, e)
    `CHK(overflow_flag_o, 1'b1)
  endtask
  // overflow branch clears the latched flag
  task automatic t_ovclr;
    @(posedge ref_clk_i);
    conditional_branch_ov_i <= 1'b1;
    @(posedge ref_clk_i);
    conditional_branch_ov_i <= 1'b0;
    #1 `CHK(overflow_flag_o, 1'b0)
  endtask
  initial
  begin
    {load_status_a_i, load_status_b_i, load_page_instr_i, set_bit_instr_i,
     clear_bit_instr_i, set_product_mode_instr_i, conditional_branch_ov_i,
     bit_test_one_i, aux_compare_true_i, normalize_instr_i, raise,
     shift_from_operand_i, add_no_extend_instr_i, load_operand_i,
     multiply_i, unsigned_multiply_instr_i, acc_load_i, acc_add_i,
     operand_from_product_i, status_data_i, bus_data_i, page_value_i,
     instr_low_i, shift_const_i, bit_sel_i, product_mode_value_i} = '0;
    arst_n_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    tick(4);
    `CHK(status_word_a_o[12:0], 13'h0600)
    `CHK(status_word_b_o[11:0], 12'h7fc)
    `CHK(overflow_flag_o, 1'b0)
    t_page();
    t_irq();
    bitop(1'b0, 3'h4);
    tick(1);
    `CHK(external_flag_out_o, 1'b0)
    t_mult();
    scale(16'h8001, 5'h04, 1'b0, 1'b0, 32'hfff80010);
    scale(16'h8001, 5'h04, 1'b0, 1'b1, 32'h00080010);
    scale(16'h8001, 5'h00, 1'b0, 1'b0, 32'hffff8001);
    scale(16'h8001, 5'h10, 1'b0, 1'b0, 32'h80010000);
    scale(16'h8001, 5'h00, 1'b1, 1'b0, 32'h80010000);
    bitop(1'b0, 3'h2);
    scale(16'h8001, 5'h04, 1'b0, 1'b0, 32'h00080010);
    @(posedge ref_clk_i);
    load_status_b_i <= 1'b1;
    status_data_i <= 16'h0001;
    @(posedge ref_clk_i);
    load_status_b_i <= 1'b0;
    tick(2);
    `CHK({status_word_b_o[11:5], status_word_b_o[3:0]}, 11'h0fd)
    t_tc(0, 1'b1);
    t_tc(1, 1'b0);
    t_tc(2, 1'b1);
    t_ovf(1'b0, 32'hfffe0000);
    t_ovf(1'b1, 32'h7fffffff);
    t_ovclr();
    give_verdict();
  end
  // run needs under a hundred cycles; a hang is cut after 5000
  initial
  begin
    #50000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
